// ===== core/fbp_flash_protect.sv
// fbp_flash_protect: flash access control and operation timing
// assumes accesses arrive as one-cycle requests synchronous to CLOCK
`timescale 1ns/1ps
module fbp_flash_protect
    import fbp_pkg::*;
#(
    parameter int FLASH_UNITS = 128
) (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic READ_REQ,
    input wire logic READ_FETCH,
    input wire logic [FBP_ADDR_W-1:0] READ_ADDR,
    input wire logic [31:0] ARRAY_RDATA,
    output logic READ_VALID,
    output logic [31:0] READ_DATA,
    input wire logic OP_PROGRAM,
    input wire logic OP_ERASE,
    input wire logic [FBP_ADDR_W-1:0] OP_ADDR,
    input wire logic [31:0] OP_WDATA,
    output logic ARRAY_WR,
    output logic ARRAY_ERASE,
    output logic [FBP_ADDR_W-1:0] ARRAY_ADDR,
    output logic [31:0] ARRAY_WDATA,
    output logic BUSY,
    output logic OP_REFUSED,
    input wire logic POL_WR,
    input wire logic POL_WR_PE,
    input wire logic [1:0] POL_WR_IDX,
    input wire logic [31:0] POL_WDATA,
    output logic [31:0] PE_POLICY_0,
    output logic [31:0] RE_POLICY_0,
    input wire logic CTRL_WR,
    input wire logic [31:0] CTRL_WDATA,
    input wire logic [31:0] TARGET_ADDR,
    input wire logic USEC_WR,
    input wire logic [7:0] USEC_WDATA,
    output logic [7:0] USEC_RELOAD,
    input wire logic FAULT_INT_MASK,
    output logic FAULT_INT
);
    // elaboration check on the unit count
    if (FLASH_UNITS < 1 || FLASH_UNITS > FBP_UNITS) begin : g_bad_units
        $error("FLASH_UNITS out of range");
    end

    // ------------------------------------------------------------
    // policy registers
    // ------------------------------------------------------------
    logic [31:0] pe_work [FBP_POL_REGS];
    logic [31:0] re_work [FBP_POL_REGS];
    logic [FBP_POL_REGS-1:0] pe_commit, re_commit;
    logic commit_go;
    wire commit_req = CTRL_WR && (CTRL_WDATA == FBP_COMMIT_KEY);

    // commit target decode from the table of addresses
    assign pe_commit[0] = commit_go && (TARGET_ADDR == FBP_TGT_PE0);
    assign pe_commit[1] = commit_go && (TARGET_ADDR == FBP_TGT_PE1);
    assign pe_commit[2] = commit_go && (TARGET_ADDR == FBP_TGT_PE2);
    assign pe_commit[3] = commit_go && (TARGET_ADDR == FBP_TGT_PE3);
    assign re_commit[0] = commit_go && (TARGET_ADDR == FBP_TGT_RE0);
    assign re_commit[1] = commit_go && (TARGET_ADDR == FBP_TGT_RE1);
    assign re_commit[2] = commit_go && (TARGET_ADDR == FBP_TGT_RE2);
    assign re_commit[3] = commit_go && (TARGET_ADDR == FBP_TGT_RE3);

    for (genvar i = 0; i < FBP_POL_REGS; i++) begin : g_pol
        wire wr_sel = POL_WR && (POL_WR_IDX == 2'(i));
        fbp_policy_reg u_pe (
            .clk(CLOCK),
            .rst_n(RST_N),
            .wr(wr_sel && POL_WR_PE),
            .wdata(POL_WDATA),
            .commit(pe_commit[i]),
            .work(pe_work[i]),
            .stored()
        );
        fbp_policy_reg u_re (
            .clk(CLOCK),
            .rst_n(RST_N),
            .wr(wr_sel && !POL_WR_PE),
            .wdata(POL_WDATA),
            .commit(re_commit[i]),
            .work(re_work[i]),
            .stored()
        );
    end

    // ------------------------------------------------------------
    // unit lookup
    // ------------------------------------------------------------
    function automatic logic pol_bit(input logic [FBP_ADDR_W-1:0] addr,
                                     input logic [31:0] regs [FBP_POL_REGS]);
        logic [FBP_UNIT_IDX_W-1:0] unit;
        unit = addr[FBP_UNIT_SHIFT +: FBP_UNIT_IDX_W];
        // unimplemented units read as open
        if (int'(unit) >= FLASH_UNITS) pol_bit = 1'b1;
        else pol_bit = regs[unit[6:5]][unit[4:0]];
    endfunction

    wire rd_re = pol_bit(READ_ADDR, re_work);
    wire op_pe = pol_bit(OP_ADDR, pe_work);
    // fetch always passes; data path needs read enable
    wire rd_ok = READ_FETCH || rd_re;
    wire op_req = OP_PROGRAM || OP_ERASE;
    wire op_ok = op_pe;

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            READ_VALID <= 1'b0;
            READ_DATA <= FBP_ZERO_WORD;
        end else begin
            READ_VALID <= READ_REQ;
            READ_DATA <= (READ_REQ && rd_ok) ? ARRAY_RDATA : FBP_ZERO_WORD;
        end
    end

    // ------------------------------------------------------------
    // reload value
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) USEC_RELOAD <= FBP_USEC_RELOAD_RST;
        else if (USEC_WR) USEC_RELOAD <= USEC_WDATA;
    end

    // ------------------------------------------------------------
    // operation sequencer
    // ------------------------------------------------------------
    fbp_state_t state_q, state_d;
    logic t_start, t_done;
    logic [FBP_TIMER_W-1:0] t_usecs;

    always_comb begin
        state_d = state_q;
        t_start = 1'b0;
        t_usecs = FBP_TIMER_W'(FBP_PROG_TIME_US);
        commit_go = 1'b0;
        case (state_q)
            FBP_IDLE: begin
                if (op_req && op_ok && OP_ERASE) begin
                    state_d = FBP_ERASE;
                    t_start = 1'b1;
                    t_usecs = FBP_TIMER_W'(FBP_ERASE_TIME_US);
                end else if (op_req && op_ok) begin
                    state_d = FBP_PROG;
                    t_start = 1'b1;
                end else if (commit_req) begin
                    state_d = FBP_COMMIT;
                    t_start = 1'b1;
                    t_usecs = FBP_TIMER_W'(FBP_COMMIT_TIME_US);
                    commit_go = 1'b1;
                end
            end
            default: begin
                if (t_done) state_d = FBP_IDLE;
            end
        endcase
    end

    fbp_usec_timer u_timer (
        .clk(CLOCK),
        .rst_n(RST_N),
        .start(t_start),
        .reload(USEC_RELOAD),
        .usecs(t_usecs),
        .done(t_done)
    );

    // array strobes; erase aligns to a 1-KB block, program ANDs data
    wire prog_go = (state_q == FBP_IDLE) && op_req && op_ok && !OP_ERASE;
    wire erase_go = (state_q == FBP_IDLE) && op_req && op_ok && OP_ERASE;
    wire refuse = (state_q == FBP_IDLE) && op_req && !op_ok;

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            state_q <= FBP_IDLE;
            ARRAY_WR <= 1'b0;
            ARRAY_ERASE <= 1'b0;
            ARRAY_ADDR <= '0;
            ARRAY_WDATA <= FBP_WORD_ERASED;
            OP_REFUSED <= 1'b0;
            FAULT_INT <= 1'b0;
            BUSY <= 1'b0;
        end else begin
            state_q <= state_d;
            BUSY <= (state_d != FBP_IDLE);
            ARRAY_WR <= prog_go;
            ARRAY_ERASE <= erase_go;
            if (prog_go || erase_go) begin
                ARRAY_ADDR <= erase_go ? {OP_ADDR[FBP_ADDR_W-1:10], 10'h000} : OP_ADDR;
                // data is ANDed with the current array word here, so zero bits never return to one
                ARRAY_WDATA <= erase_go ? FBP_WORD_ERASED : OP_WDATA & ARRAY_RDATA;
            end
            OP_REFUSED <= refuse;
            FAULT_INT <= FAULT_INT_MASK &&
                (refuse || (READ_REQ && !rd_ok));
        end
    end

    // ------------------------------------------------------------
    // status outputs
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            PE_POLICY_0 <= FBP_POL_RESET;
            RE_POLICY_0 <= FBP_POL_RESET;
        end else begin
            PE_POLICY_0 <= pe_work[0];
            RE_POLICY_0 <= re_work[0];
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    refuse_blocks_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        refuse |=> !ARRAY_WR && !ARRAY_ERASE && OP_REFUSED)
        else $error("refused change reached the array");
    zero_on_block_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        READ_REQ && !rd_ok |=> READ_VALID && READ_DATA == 32'h00000000)
        else $error("blocked read leaked data");
    fetch_passes_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        READ_REQ && READ_FETCH |=> READ_DATA == $past(ARRAY_RDATA))
        else $error("fetch was blocked");
    fault_mask_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        !FAULT_INT_MASK |=> !FAULT_INT)
        else $error("fault raised while masked");
    reload_reset_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        $rose(RST_N) |-> USEC_RELOAD == 8'h31)
        else $error("reload reset value wrong");
    erase_ones_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        ARRAY_ERASE |-> ARRAY_WDATA == 32'hFFFFFFFF && ARRAY_ADDR[9:0] == 10'h000)
        else $error("erase not whole block of ones");
    prog_clears_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        prog_go |=> (ARRAY_WDATA & ~$past(ARRAY_RDATA)) == 32'h00000000)
        else $error("program set a zero bit");
    commit_busy_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        commit_req && state_q == FBP_IDLE && !op_req |=> BUSY)
        else $error("commit did not start");
    usec_load_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        USEC_WR |=> USEC_RELOAD == $past(USEC_WDATA))
        else $error("reload not loaded");

    // ------------------------------------------------------------
    // sequencing checks
    // ------------------------------------------------------------
    // every read is answered; blocked ones are reported when unmasked
    read_valid_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        READ_REQ |=> READ_VALID)
        else $error("read not answered");
    blocked_fault_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        FAULT_INT_MASK && READ_REQ && !rd_ok |=> FAULT_INT)
        else $error("blocked read not flagged");
    refuse_fault_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        FAULT_INT_MASK && refuse |=> FAULT_INT)
        else $error("refused change not flagged");
    fetch_quiet_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        READ_REQ && READ_FETCH && !op_req |=> !FAULT_INT)
        else $error("fetch raised a fault");
    // requests met while busy are dropped with no strobe and no refusal
    busy_ignores_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        state_q != FBP_IDLE |=> !ARRAY_WR && !ARRAY_ERASE && !OP_REFUSED)
        else $error("request taken while busy");
    busy_rise_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        prog_go || erase_go |=> BUSY)
        else $error("operation did not raise busy");
    done_idle_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        t_done && state_q != FBP_IDLE |=> !BUSY)
        else $error("busy outlived the timer");
    reload_hold_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        !USEC_WR |=> $stable(USEC_RELOAD))
        else $error("reload moved without a write");
    // program strobes carry the address that was asked for; erase strobes carry its 1-KB block
    prog_addr_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        prog_go |=> ARRAY_WR && ARRAY_ADDR == $past(OP_ADDR))
        else $error("program strobe address wrong");
    erase_addr_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        erase_go |=> ARRAY_ERASE &&
            ARRAY_ADDR[FBP_ADDR_W-1:10] == $past(OP_ADDR[FBP_ADDR_W-1:10]))
        else $error("erase strobe block wrong");
    unimpl_open_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        state_q == FBP_IDLE && op_req &&
            int'(OP_ADDR[FBP_UNIT_SHIFT +: FBP_UNIT_IDX_W]) >= FLASH_UNITS |=> !OP_REFUSED)
        else $error("unimplemented unit refused");
    commit_start_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        commit_req && state_q == FBP_IDLE && !op_req |-> commit_go)
        else $error("commit key not honoured");
endmodule

// ===== pkg/fbp_pkg.sv
// fbp_pkg: constants for the flash block protection and timing logic
// assumes a 40 MHz system clock and a single power-on reset
package fbp_pkg;
    // ------------------------------------------------------------
    // array geometry
    // ------------------------------------------------------------
    localparam int FBP_ADDR_W = 18;
    localparam int FBP_ERASE_BLK_BYTES = 1024;
    localparam int FBP_UNIT_BYTES = 2048;
    localparam int FBP_UNIT_SHIFT = 11;
    localparam int FBP_POL_REGS = 4;
    localparam int FBP_POL_W = 32;
    localparam int FBP_UNITS = FBP_POL_REGS * FBP_POL_W;
    localparam int FBP_UNIT_IDX_W = 7;
    localparam logic [31:0] FBP_WORD_ERASED = 32'hFFFFFFFF;
    localparam logic [31:0] FBP_POL_RESET = 32'hFFFFFFFF;
    localparam logic [31:0] FBP_ZERO_WORD = 32'h00000000;

    // ------------------------------------------------------------
    // command and commit encodings
    // ------------------------------------------------------------
    localparam logic [31:0] FBP_COMMIT_KEY = 32'hA4420008;
    localparam logic [31:0] FBP_TGT_RE0 = 32'h00000000;
    localparam logic [31:0] FBP_TGT_PE0 = 32'h00000001;
    localparam logic [31:0] FBP_TGT_RE1 = 32'h00000002;
    localparam logic [31:0] FBP_TGT_PE1 = 32'h00000003;
    localparam logic [31:0] FBP_TGT_RE2 = 32'h00000004;
    localparam logic [31:0] FBP_TGT_PE2 = 32'h00000005;
    localparam logic [31:0] FBP_TGT_PE3 = 32'h00000007;
    localparam logic [31:0] FBP_TGT_RE3 = 32'h00000008;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam logic [7:0] FBP_USEC_RELOAD_RST = 8'h31;
    localparam int FBP_PROG_TIME_US = 20;
    localparam int FBP_ERASE_TIME_US = 20;
    localparam int FBP_COMMIT_TIME_US = 20;
    localparam int FBP_TIMER_W = 16;

    typedef enum logic [3:0] {
        FBP_IDLE = 4'h1,
        FBP_PROG = 4'h2,
        FBP_ERASE = 4'h4,
        FBP_COMMIT = 4'h8
    } fbp_state_t;
endpackage

// ===== core/fbp_usec_timer.sv
// fbp_usec_timer: counts whole microseconds from a cycles-per-usec reload
// assumes reload holds cycles-per-microsecond minus one
`timescale 1ns/1ps
module fbp_usec_timer
    import fbp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [7:0] reload,
    input wire logic [FBP_TIMER_W-1:0] usecs,
    output logic done
);
    logic [7:0] cyc_q;
    logic [FBP_TIMER_W-1:0] us_q;
    logic run_q;
    wire tick = run_q && (cyc_q == 8'h00);
    wire last = tick && (us_q == {{(FBP_TIMER_W-1){1'b0}}, 1'b1});

    // ------------------------------------------------------------
    // microsecond prescaler and down counter
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cyc_q <= 8'h00;
            us_q <= '0;
            run_q <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= last;
            if (start) begin
                cyc_q <= reload;
                us_q <= usecs;
                run_q <= 1'b1;
            end else if (tick) begin
                cyc_q <= reload;
                us_q <= us_q - 1'b1;
                run_q <= !last;
            end else if (run_q) begin
                cyc_q <= cyc_q - 8'h01;
            end
        end
    end
endmodule

// ===== core/fbp_policy_reg.sv
// fbp_policy_reg: one 32-bit policy register, working and stored copies
// assumes stored copy stands in for the nonvolatile cell
`timescale 1ns/1ps
module fbp_policy_reg
    import fbp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr,
    input wire logic [31:0] wdata,
    input wire logic commit,
    output logic [31:0] work,
    output logic [31:0] stored
);
    // ------------------------------------------------------------
    // working copy reloads from the stored copy at power-on
    // ------------------------------------------------------------
    logic loaded_q;
    // factory state of the cell; no reset so contents survive
    logic [31:0] stored_q = FBP_POL_RESET;
    // a write lands under the stored copy, as it stands after any commit
    wire [31:0] stored_d = commit ? (stored_q & work) : stored_q;
    assign stored = stored_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            work <= FBP_POL_RESET;
            loaded_q <= 1'b0;
        end else begin
            loaded_q <= 1'b1;
            if (!loaded_q) work <= stored_q;
            else if (wr) work <= wdata & stored_d;
        end
    end

    // stored cells only ever lose ones
    always_ff @(posedge clk) begin
        stored_q <= stored_d;
    end

    // a write may never reopen a unit that a commit has closed
    reopen_block_a: assert property (@(posedge clk) disable iff (!rst_n)
        loaded_q |-> (work & ~stored_q) == 32'h00000000)
        else $error("write reopened a committed bit");
endmodule

// ===== verification/fbp_array_model.sv
// fbp_array_model: behavioural flash array facing the protection block
// assumes one write or erase strobe per cycle and word-aligned addresses
`timescale 1ns/1ps
module fbp_array_model
    import fbp_pkg::*;
(
    input wire logic clk,
    input wire logic wr,
    input wire logic erase,
    input wire logic [FBP_ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic [FBP_ADDR_W-1:0] raddr,
    output logic [31:0] rdata
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [31:0] mem [0:65535];

    // blank cells hold a pattern, not ones, so that an erase is visible
    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 32'hC3C30000 ^ 32'(i);
        end
    end

    // store whatever the block sends; an erase fills the 1-KB block
    always @(posedge clk) begin
        if (wr) begin
            mem[addr[17:2]] <= wdata;
        end
        if (erase) begin
            for (int i = 0; i < 256; i++) begin
                mem[{addr[17:10], 8'(i)}] <= wdata;
            end
        end
    end

    // same-cycle read path, as the block expects
    assign rdata = mem[raddr[17:2]];
endmodule

// ===== verification/tb.sv
// tb: self-checking bench for the flash protection and timing block
// assumes fbp_pkg compiled first and the array model beside the design
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin error_cnt++; $display("BAD t=%0t got %h exp %h", $time, got, exp); end end
module tb;
    import fbp_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic clock, rst_n, read_req, read_fetch, read_valid, op_program, op_erase;
    logic [17:0] read_addr, op_addr, array_addr;
    logic [31:0] array_rdata, read_data, op_wdata, array_wdata, pol_wdata, pe_pol, re_pol;
    logic array_wr, array_erase, busy, op_refused, pol_wr, pol_wr_pe, ctrl_wr;
    logic [1:0] pol_wr_idx;
    logic [31:0] ctrl_wdata, target_addr;
    logic usec_wr, fault_int_mask, fault_int;
    logic [7:0] usec_wdata, usec_reload;
    logic [17:0] a;
    logic [31:0] w;
    logic pe, re;
    int error_cnt = 0;
    int samples_checked = 0;
    int op_cyc = 1000;

    // units above 63 stay open, which the mapping scenario relies on
    fbp_flash_protect #(.FLASH_UNITS(64)) fbp_flash_protect_i (
        .CLOCK(clock), .RST_N(rst_n), .READ_REQ(read_req), .READ_FETCH(read_fetch),
        .READ_ADDR(read_addr), .ARRAY_RDATA(array_rdata), .READ_VALID(read_valid),
        .READ_DATA(read_data), .OP_PROGRAM(op_program), .OP_ERASE(op_erase),
        .OP_ADDR(op_addr), .OP_WDATA(op_wdata), .ARRAY_WR(array_wr),
        .ARRAY_ERASE(array_erase), .ARRAY_ADDR(array_addr), .ARRAY_WDATA(array_wdata),
        .BUSY(busy), .OP_REFUSED(op_refused), .POL_WR(pol_wr), .POL_WR_PE(pol_wr_pe),
        .POL_WR_IDX(pol_wr_idx), .POL_WDATA(pol_wdata), .PE_POLICY_0(pe_pol),
        .RE_POLICY_0(re_pol), .CTRL_WR(ctrl_wr), .CTRL_WDATA(ctrl_wdata),
        .TARGET_ADDR(target_addr), .USEC_WR(usec_wr), .USEC_WDATA(usec_wdata),
        .USEC_RELOAD(usec_reload), .FAULT_INT_MASK(fault_int_mask), .FAULT_INT(fault_int));

    fbp_array_model fbp_array_model_i (.clk(clock), .wr(array_wr), .erase(array_erase),
        .addr(array_addr), .wdata(array_wdata), .raddr(read_addr), .rdata(array_rdata));

    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    // every input moves 2 ns after the rising edge, never on it
    task automatic tick();
        @(posedge clock);
        #2;
    endtask

    task automatic do_reset();
        rst_n = 1'b0;
        op_cyc = FBP_PROG_TIME_US * (int'(FBP_USEC_RELOAD_RST) + 1);
        repeat (5) tick();
        rst_n = 1'b1;
        tick();
    endtask

    // busy wait is bounded so a stuck flag cannot hang the run
    task automatic wait_idle(output int cnt);
        cnt = 0;
        while (busy === 1'b1 && cnt < 3000) begin
            tick();
            cnt++;
        end
    endtask

    task automatic do_read(input logic [17:0] ad, input logic f, input logic [31:0] ex,
                           input logic ef);
        read_addr = ad;
        read_fetch = f;
        read_req = 1'b1;
        tick();
        read_req = 1'b0;
        `CHK(read_valid, 1'b1)
        `CHK(read_data, ex)
        `CHK(fault_int, ef)
        tick();
    endtask

    // read_addr follows op_addr so the design sees the current word
    task automatic do_op(input logic er, input logic [17:0] ad, input logic [31:0] d,
                         input logic ref_exp);
        int cnt;
        op_addr = ad;
        read_addr = ad;
        op_wdata = d;
        op_program = !er;
        op_erase = er;
        tick();
        op_program = 1'b0;
        op_erase = 1'b0;
        `CHK(op_refused, ref_exp)
        `CHK(fault_int, ref_exp & fault_int_mask)
        `CHK(er ? array_erase : array_wr, !ref_exp)
        `CHK(busy, !ref_exp)
        wait_idle(cnt);
        if (!ref_exp) begin
            `CHK(cnt >= op_cyc - 1 && cnt <= op_cyc + 3, 1'b1)
        end
        tick();
    endtask

    task automatic write_policy(input logic p, input logic [1:0] idx, input logic [31:0] d);
        pol_wr_pe = p;
        pol_wr_idx = idx;
        pol_wdata = d;
        pol_wr = 1'b1;
        tick();
        pol_wr = 1'b0;
        tick();
    endtask

    task automatic commit(input logic [31:0] key, input logic [31:0] tgt, input logic eb);
        int cnt;
        target_addr = tgt;
        ctrl_wdata = key;
        ctrl_wr = 1'b1;
        tick();
        ctrl_wr = 1'b0;
        `CHK(busy, eb)
        wait_idle(cnt);
        `CHK(busy, 1'b0)
        tick();
    endtask

    // the bench sets the reload below clock MHz minus one to shorten waits; op_cyc follows it
    task automatic set_usec(input logic [7:0] v);
        usec_wdata = v;
        usec_wr = 1'b1;
        tick();
        usec_wr = 1'b0;
        op_cyc = FBP_PROG_TIME_US * (int'(v) + 1);
        `CHK(usec_reload, v)
    endtask

    task automatic summarize();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // clock, watchdog and test sequence
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // whole run is a few thousand cycles; this leaves wide margin
    initial begin
        repeat (40000) @(posedge clock);
        error_cnt++;
        summarize();
    end

    initial begin
        {read_req, read_fetch, op_program, op_erase, pol_wr, pol_wr_pe} = '0;
        {ctrl_wr, usec_wr, fault_int_mask} = '0;
        {read_addr, op_addr, pol_wr_idx, usec_wdata} = '0;
        {op_wdata, pol_wdata, ctrl_wdata, target_addr} = '0;
        do_reset();
        `CHK(usec_reload, FBP_USEC_RELOAD_RST)
        `CHK(pe_pol, FBP_POL_RESET)
        `CHK(re_pol, FBP_POL_RESET)
        set_usec(8'h03);
        do_op(1'b1, 18'h00400, 32'h0, 1'b0);
        do_read(18'h00404, 1'b0, FBP_WORD_ERASED, 1'b0);
        do_op(1'b0, 18'h00404, 32'h0F0FFFFF, 1'b0);
        do_op(1'b0, 18'h00404, 32'hFFFF00FF, 1'b0);
        do_read(18'h00404, 1'b0, 32'h0F0F00FF, 1'b0);
        // units 1..4 walk the four policy combinations
        write_policy(1'b1, 2'd0, 32'hFFFFFFF9);
        write_policy(1'b0, 2'd0, 32'hFFFFFFF3);
        `CHK(pe_pol, 32'hFFFFFFF9)
        `CHK(re_pol, 32'hFFFFFFF3)
        for (int u = 1; u <= 4; u++) begin
            pe = u > 2;
            re = (u == 1) || (u == 4);
            fault_int_mask = u[0];
            a = 18'(u << 11);
            w = pe ? 32'h12345678 : (32'hC3C30000 ^ 32'(a >> 2));
            do_op(1'b1, a, 32'h0, !pe);
            do_op(1'b0, a, 32'h12345678, !pe);
            do_read(a, 1'b0, re ? w : FBP_ZERO_WORD, !re & fault_int_mask);
            do_read(a, 1'b1, w, 1'b0);
        end
        write_policy(1'b1, 2'd1, 32'hFFFFFFEF);
        do_op(1'b0, 18'(36 << 11), 32'h0, 1'b1);
        write_policy(1'b1, 2'd3, 32'hFFFFFFEF);
        do_op(1'b0, 18'(100 << 11), 32'h0, 1'b0);
        // uncommitted clears fall back at power-on reset
        do_reset();
        `CHK(pe_pol, FBP_POL_RESET)
        do_op(1'b0, 18'h00800, 32'h0, 1'b0);
        write_policy(1'b1, 2'd0, 32'hFFFFFFFE);
        commit(32'hA4420001, FBP_TGT_PE0, 1'b0);
        commit(FBP_COMMIT_KEY, FBP_TGT_PE0, 1'b1);
        write_policy(1'b1, 2'd0, 32'hFFFFFFFF);
        `CHK(pe_pol, 32'hFFFFFFFE)
        commit(FBP_COMMIT_KEY, FBP_TGT_PE0, 1'b1);
        do_reset();
        tick();
        `CHK(pe_pol, 32'hFFFFFFFE)
        do_op(1'b1, 18'h00000, 32'h0, 1'b1);
        summarize();
    end
endmodule
